// ==== crc_scan_pkg.sv ====
// Constants and types shared by the code memory check unit
package crc_scan_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [1:0] IDX_CONTROL = 2'h0;  // scan_control
   localparam logic [1:0] IDX_SECTION = 2'h1;  // scan_section_select
   localparam logic [1:0] IDX_STATUS  = 2'h2;  // scan_status
   localparam int         WORD_SHIFT  = 2;     // Index to byte address

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         CTRL_ENABLE_BIT = 0;
   localparam int         CTRL_IRQEN_BIT  = 1;
   localparam int         CTRL_RESET_BIT  = 7;
   localparam int         STAT_BUSY_BIT   = 0;
   localparam int         STAT_OK_BIT     = 1;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [7:0] SECTION_RESET   = 8'h00;
   localparam logic [7:0] STATUS_RESET    = 8'h02;

   // ----------------------------------------------------------------
   // Timing, sizes and checksum
   // ----------------------------------------------------------------
   localparam logic [1:0]  START_DELAY_CYC = 2'h3;  // Enable write to scan start
   localparam logic [1:0]  FETCH_CYC       = 2'h3;  // Cycles per 16-bit fetch
   localparam int          BYTE_ADDR_W     = 15;    // 32 KB code memory
   localparam int          WORD_ADDR_W     = 14;
   localparam logic [15:0] CRC_INIT        = 16'hffff;
   localparam logic [15:0] CRC_POLY        = 16'h1021;
   localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

   // Section field encodings
   typedef enum logic [1:0] {
      SECT_WHOLE_MEMORY = 2'h0,
      SECT_LOADER_AND_PROGRAM = 2'h1,
      SECT_LOADER_ONLY = 2'h2,
      SECT_RESERVED = 2'h3
   } section_t;

   // AHB transfer type and response codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY    = 2'h0;

endpackage

// ==== memory_check_unit.sv ====
// Code memory checksum scanner with AHB-Lite register slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Reset strobe clears enable, section and status one cycle after the write; fatal interrupt enable is kept.
// - With fatal interrupt disabled, reset strobe works even during a scan.
// - With fatal interrupt enabled, reset strobe is ignored while busy.
// - Reset bit is a strobe and always reads zero.
// - With fatal interrupt enabled, every checksum mismatch raises the fatal request.
// - Fatal interrupt enable clears only on system reset.
// - Setting fatal interrupt enable is ignored while a scan is busy.
// - After the fatal request fires, control register writes are ignored.
// - Writing enable one starts a check; enable stays one afterwards.
// - Writing enable zero does nothing to the bit or the scan.
// - Start-up scan leaves enable one and the configured section visible.
// - Section register ignores writes while busy or after the fatal request.
// - Section field: whole memory, loader plus program, loader only, reserved.
// - Match flag resets to one; status resets to two.
// - Busy reads one for the whole scan and locks section writes, starts and fatal interrupt enable setting.
// - Scan begins three cycles after the enable write.
// - A mismatch clears the match flag and, with fatal interrupt enabled, raises the fatal request.
// - Fatal request stays active until system reset.
// - Scanning stalls the processor; each 16-bit fetch takes three cycles.
module memory_check_unit
(
   // Clock and reset
   input  wire logic                                 hclk,
   input  wire logic                                 hresetn,
   // AHB-Lite slave
   input  wire logic                                 hsel,
   input  wire logic [31:0]                          haddr,
   input  wire logic [1:0]                           htrans,
   input  wire logic                                 hwrite,
   input  wire logic [2:0]                           hsize,
   input  wire logic [31:0]                          hwdata,
   input  wire logic                                 hready,
   output logic      [31:0]                          hrdata,
   output logic                                      hreadyout,
   output logic      [1:0]                           hresp,
   // Start-up straps and section sizes
   input  wire logic                                 boot_scan_en,
   input  wire logic [1:0]                           boot_scan_section,
   input  wire logic [crc_scan_pkg::BYTE_ADDR_W-1:0] loader_end,
   input  wire logic [crc_scan_pkg::BYTE_ADDR_W-1:0] program_end,
   input  wire logic [crc_scan_pkg::BYTE_ADDR_W-1:0] memory_end,
   // Code memory read path
   output logic                                      mem_req,
   output logic      [crc_scan_pkg::WORD_ADDR_W-1:0] mem_word_addr,
   input  wire logic [15:0]                          mem_rdata,
   // Processor side
   output logic                                      cpu_stall,
   output logic                                      fatal_irq
);

   typedef enum logic [1:0] {IDLE, WAIT_START, FETCH} scan_state_t;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   scan_state_t                        st_r, st_nxt;
   logic [1:0]                         cnt_r, cnt_nxt;
   logic [crc_scan_pkg::WORD_ADDR_W-1:0] wa_r, wa_nxt, wend_r;
   logic [15:0]                        crc_r, crc_nxt;
   logic                               enable_r, irq_en_r, busy_r, ok_r;
   logic [1:0]                         section_r;
   logic                               rst_pend_r, boot_pend_r;
   logic                               wr_act_r;
   logic [1:0]                         wr_idx_r;
   logic                               mem_req_r, cpu_stall_r, fatal_irq_r;
   logic [31:0]                        hrdata_r;
   logic                               hreadyout_r;
   logic [1:0]                         hresp_r;

   // CRC-16 over one byte, most significant bit first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         if (r[15] ^ d[i])
            r = {r[14:0], 1'b0} ^ crc_scan_pkg::CRC_POLY;
         else
            r = {r[14:0], 1'b0};
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire        addr_ph   = hsel && hready && (htrans == crc_scan_pkg::HTRANS_NONSEQ);
   wire [1:0]  a_idx     = haddr[3:2];
   wire        a_mapped  = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0)
                           && (a_idx <= crc_scan_pkg::IDX_STATUS);
   wire [7:0]  wd        = hwdata[7:0];
   wire        wr_ctrl   = wr_act_r && (wr_idx_r == crc_scan_pkg::IDX_CONTROL)
                           && !fatal_irq_r;
   wire        wr_sect   = wr_act_r && (wr_idx_r == crc_scan_pkg::IDX_SECTION)
                           && !busy_r && !fatal_irq_r;
   // Strobe accepted freely when fatal interrupt is off, else only when idle
   wire        rst_ok    = wr_ctrl && wd[crc_scan_pkg::CTRL_RESET_BIT]
                           && (!irq_en_r || !busy_r);
   wire        irqen_set = wr_ctrl && wd[crc_scan_pkg::CTRL_IRQEN_BIT] && !busy_r;
   // A new check needs an idle scanner; a zero write is simply not a start
   wire        start_sw  = wr_ctrl && wd[crc_scan_pkg::CTRL_ENABLE_BIT]
                           && !busy_r && !rst_ok;
   wire        start_bt  = boot_pend_r && boot_scan_en;
   wire        start_ok  = (start_sw || start_bt) && !rst_pend_r;

   // Read data mux; reset strobe is never stored so reads as zero
   wire [7:0]  rd_ctrl   = {6'h00, irq_en_r, enable_r};
   wire [7:0]  rd_stat   = {6'h00, ok_r, busy_r};
   wire [7:0]  rd_byte   = !a_mapped ? 8'h00 :
                           (a_idx == crc_scan_pkg::IDX_CONTROL) ? rd_ctrl :
                           (a_idx == crc_scan_pkg::IDX_SECTION) ? {6'h00, section_r} :
                           rd_stat;

   // ----------------------------------------------------------------
   // Scan sequencer
   // ----------------------------------------------------------------
   wire [15:0] crc_word  = crc_byte(crc_byte(crc_r, mem_rdata[7:0]), mem_rdata[15:8]);
   wire        fetch_end = (st_r == FETCH) && (cnt_r == crc_scan_pkg::FETCH_CYC - 2'h1);
   wire        last_word = fetch_end && (wa_r == wend_r);
   wire        match     = (crc_word == crc_scan_pkg::CRC_RESIDUE);
   wire        fail      = last_word && !match && !rst_pend_r;
   wire [1:0]  sect_go   = start_bt ? boot_scan_section : section_r;
   wire [crc_scan_pkg::BYTE_ADDR_W-1:0] end_sel =
               (sect_go == crc_scan_pkg::SECT_LOADER_ONLY)        ? loader_end  :
               (sect_go == crc_scan_pkg::SECT_LOADER_AND_PROGRAM) ? program_end :
               memory_end;
   wire        in_wait   = (st_r == WAIT_START);
   wire        in_fetch  = (st_r == FETCH);

   // Next state: start delay, then three-cycle word fetches
   always_comb
   begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      wa_nxt  = wa_r;
      crc_nxt = crc_r;
      unique case (st_r)
         IDLE:
         begin
            if (start_ok)
            begin
               st_nxt  = WAIT_START;
               cnt_nxt = 2'h0;
               wa_nxt  = '0;
               crc_nxt = crc_scan_pkg::CRC_INIT;
            end
         end
         WAIT_START:
         begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == crc_scan_pkg::START_DELAY_CYC - 2'h1)
            begin
               st_nxt  = FETCH;
               cnt_nxt = 2'h0;
            end
         end
         FETCH:
         begin
            cnt_nxt = cnt_r + 2'h1;
            if (fetch_end)
            begin
               cnt_nxt = 2'h0;
               crc_nxt = crc_word;
               wa_nxt  = wa_r + 1'b1;
               if (last_word)
                  st_nxt = IDLE;
            end
         end
      endcase
      if (rst_pend_r)
         st_nxt = IDLE;
   end

   // Sequencer registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r  <= IDLE;
         cnt_r <= 2'h0;
         wa_r  <= '0;
         crc_r <= crc_scan_pkg::CRC_INIT;
      end
      else
      begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         wa_r  <= wa_nxt;
         crc_r <= crc_nxt;
      end
   end

   // Section end latched at start so later sizes cannot move it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wend_r <= '0;
      else if (start_ok)
         wend_r <= end_sel[crc_scan_pkg::BYTE_ADDR_W-1:1];
   end

   // ----------------------------------------------------------------
   // Registers seen by software
   // ----------------------------------------------------------------
   // Strap is sampled on the first edge after reset release
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         boot_pend_r <= 1'b1;
      else
         boot_pend_r <= 1'b0;
   end

   // Strobe clears one cycle after its write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rst_pend_r <= 1'b0;
      else
         rst_pend_r <= rst_ok;
   end

   // Control and section fields
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         enable_r  <= crc_scan_pkg::CONTROL_RESET[crc_scan_pkg::CTRL_ENABLE_BIT];
         irq_en_r  <= crc_scan_pkg::CONTROL_RESET[crc_scan_pkg::CTRL_IRQEN_BIT];
         section_r <= crc_scan_pkg::SECTION_RESET[1:0];
      end
      else if (rst_pend_r)
      begin
         // Interrupt enable survives the strobe; only system reset drops it
         enable_r  <= crc_scan_pkg::CONTROL_RESET[crc_scan_pkg::CTRL_ENABLE_BIT];
         section_r <= crc_scan_pkg::SECTION_RESET[1:0];
      end
      else
      begin
         if (start_ok)
            enable_r <= 1'b1;
         if (start_bt)
            section_r <= boot_scan_section;
         else if (wr_sect)
            section_r <= wd[1:0];
         if (irqen_set)
            irq_en_r <= 1'b1;
      end
   end

   // Status flags; busy covers start delay and scan
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         busy_r <= crc_scan_pkg::STATUS_RESET[crc_scan_pkg::STAT_BUSY_BIT];
         ok_r   <= crc_scan_pkg::STATUS_RESET[crc_scan_pkg::STAT_OK_BIT];
      end
      else if (rst_pend_r)
      begin
         busy_r <= crc_scan_pkg::STATUS_RESET[crc_scan_pkg::STAT_BUSY_BIT];
         ok_r   <= crc_scan_pkg::STATUS_RESET[crc_scan_pkg::STAT_OK_BIT];
      end
      else if (last_word)
      begin
         busy_r <= 1'b0;
         ok_r   <= match;
      end
      else if (start_ok)
      begin
         busy_r <= 1'b1;
         ok_r   <= crc_scan_pkg::STATUS_RESET[crc_scan_pkg::STAT_OK_BIT];
      end
   end

   // Fatal request is sticky until system reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         fatal_irq_r <= 1'b0;
      else if (fail && irq_en_r)
         fatal_irq_r <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Memory, stall and bus outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_req_r   <= 1'b0;
         cpu_stall_r <= 1'b0;
         wr_act_r    <= 1'b0;
         wr_idx_r    <= 2'h0;
         hrdata_r    <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r     <= crc_scan_pkg::HRESP_OKAY;
      end
      else
      begin
         mem_req_r   <= (st_nxt == FETCH);
         cpu_stall_r <= (st_nxt == FETCH);
         wr_act_r    <= addr_ph && hwrite && a_mapped;
         wr_idx_r    <= a_idx;
         hrdata_r    <= {24'h000000, rd_byte};
         hreadyout_r <= 1'b1;
         hresp_r     <= crc_scan_pkg::HRESP_OKAY;
      end
   end

   assign mem_word_addr = wa_r;
   assign mem_req       = mem_req_r;
   assign cpu_stall     = cpu_stall_r;
   assign fatal_irq     = fatal_irq_r;
   assign hrdata        = hrdata_r;
   assign hreadyout     = hreadyout_r;
   assign hresp         = hresp_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   strobe_clear_a: assert property (rst_pend_r |=> !enable_r && section_r == 2'h0
                                    && !busy_r && ok_r && st_r == IDLE)
      else $error("reset strobe did not clear registers");
   strobe_busy_a: assert property (wr_ctrl && wd[crc_scan_pkg::CTRL_RESET_BIT]
                                   && irq_en_r && busy_r |=> !rst_pend_r)
      else $error("reset strobe taken while busy with interrupt enabled");
   irqen_keep_a: assert property (irq_en_r |=> irq_en_r)
      else $error("interrupt enable dropped without system reset");
   irqen_lock_a: assert property (busy_r && !irq_en_r && wr_ctrl |=> !irq_en_r)
      else $error("interrupt enable set during scan");
   ctrl_lock_a: assert property (fatal_irq_r && wr_act_r |=> $stable(enable_r)
                                 && $stable(section_r) && !rst_pend_r)
      else $error("write accepted after fatal request");
   fail_irq_a: assert property (fail && irq_en_r |=> fatal_irq_r && !ok_r)
      else $error("mismatch did not raise fatal request");
   irq_sticky_a: assert property (fatal_irq_r |=> fatal_irq_r [*8])
      else $error("fatal request dropped");
   start_delay_a: assert property ($rose(in_fetch) |-> $past(in_wait, 1) && $past(in_wait, 2)
                                   && $past(in_wait, 3) && !$past(in_wait, 4))
      else $error("scan start delay wrong");
   fetch_len_a: assert property (fetch_end |-> $past(in_fetch, 1) && $past(in_fetch, 2)
                                 && cpu_stall_r)
      else $error("fetch shorter than three cycles");
   done_flags_a: assert property (last_word && !rst_pend_r |=> !busy_r && ok_r == $past(match)
                                  && !cpu_stall_r)
      else $error("completion flags wrong");
   stall_busy_a: assert property (cpu_stall_r |-> busy_r)
      else $error("stall outside busy");
   sect_lock_a: assert property (busy_r && !start_bt && !rst_pend_r
                                 |=> $stable(section_r))
      else $error("section changed during scan");

endmodule

`default_nettype wire

// ==== code_memory_model.sv ====
// Behavioural code memory that answers the scanner's fetches
`timescale 1ns/1ps
`default_nettype none
module code_memory_model
(
   // Clock
   input  wire logic        hclk,
   // Fetch port
   input  wire logic        mem_req,
   input  wire logic [13:0] mem_word_addr,
   output logic      [15:0] mem_rdata,
   // Fault injection
   input  wire logic        corrupt
);
   logic [7:0]  mem [0:63];
   logic [15:0] junk_r = 16'h5a5a;
   wire  logic [4:0] wa;

   // ----
   // Image with a checksum at each section end
   // ----
   function automatic logic [15:0] crc_of(input int last);
      logic [15:0] c;
      c = 16'hffff;
      for (int i = 0; i <= last; i++)
      begin
         c = c ^ {mem[i], 8'h00};
         for (int b = 0; b < 8; b++)
         begin
            c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
         end
      end
      return c;
   endfunction

   initial
   begin
      for (int i = 0; i < 64; i++)
      begin
         mem[i] = 8'(i * 37 + 5);
      end
      {mem[14], mem[15]} = crc_of(13);
      {mem[30], mem[31]} = crc_of(29);
      {mem[62], mem[63]} = crc_of(61);
   end

   // Idle bus shows a moving pattern so stale data never looks valid
   always_ff @(posedge hclk)
      junk_r <= ~junk_r + 16'h0001;

   // Word answer, first byte flipped on request to force a mismatch
   assign wa        = mem_word_addr[4:0];
   assign mem_rdata = !mem_req ? junk_r :
      {mem[{wa, 1'b1}], mem[{wa, 1'b0}] ^ {8{corrupt && wa == 5'h00}}};
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the memory check unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        boot_en = 1'b0;
   logic [1:0]  boot_sec = 2'h0;
   logic        corrupt = 1'b0;
   logic        rd_pend = 1'b0;
   logic [15:0] exp_q [$];
   wire  logic [31:0] hrdata;
   wire  logic [1:0]  hresp;
   wire  logic        hreadyout, mem_req, cpu_stall, fatal_irq;
   wire  logic [13:0] mem_word_addr;
   wire  logic [15:0] mem_rdata;
   int error_cnt = 0;
   int comparisons = 0;
   int seed = 77;
   int cycles = 0;
   int stall_cnt = 0;

   initial
      forever #2.5 hclk = ~hclk;

   memory_check_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .boot_scan_en(boot_en),
      .boot_scan_section(boot_sec), .loader_end(15'h000f), .program_end(15'h001f),
      .memory_end(15'h003f), .mem_req(mem_req), .mem_word_addr(mem_word_addr),
      .mem_rdata(mem_rdata), .cpu_stall(cpu_stall), .fatal_irq(fatal_irq));

   code_memory_model mem_model (.hclk(hclk), .mem_req(mem_req),
      .mem_word_addr(mem_word_addr), .mem_rdata(mem_rdata), .corrupt(corrupt));

   // ----
   // Checking and closing
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Read data taken at the data-phase edge, masked where a bit is not yet meaningful
   always @(posedge hclk)
   begin
      cycles++;
      if (cpu_stall === 1'b1)
         stall_cnt++;
      if (rd_pend && hreadyout === 1'b1)
      begin
         chk({30'h0, hresp}, {30'h0, crc_scan_pkg::HRESP_OKAY});
         chk(hrdata & {24'h0, exp_q[0][15:8]}, {24'h0, exp_q[0][7:0]});
         void'(exp_q.pop_front());
      end
      rd_pend <= hsel && htrans == crc_scan_pkg::HTRANS_NONSEQ && !hwrite;
      if (cycles > 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ----
   // Bus master: address phase, then data phase, each held until hready
   // ----
   task automatic bus(input logic wr, input logic [1:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= crc_scan_pkg::HTRANS_NONSEQ;
      haddr <= {28'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
   endtask

   task automatic rd(input logic [1:0] idx, input logic [7:0] e, input logic [7:0] m = 8'hff);
      exp_q.push_back({m, e & m});
      bus(1'b0, idx, 8'h00);
   endtask

   task automatic wr(input logic [1:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   // Waits out a scan and checks how long the processor was held
   task automatic finish(input int s0, input int words);
      repeat (3 * words + 8) @(posedge hclk);
      chk(stall_cnt - s0, 3 * words);
   endtask

   function automatic int words(input int s);
      return (s == 1) ? 16 : (s == 2) ? 8 : 32;
   endfunction

   // ----
   // Main sequence
   // ----
   initial
   begin
      int s0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h02);
      rd(2'h3, 8'h00);
      // Every section code, with locked writes thrown at a busy scan
      for (int s = 0; s < 4; s++)
      begin
         s0 = stall_cnt;
         wr(2'h1, 8'(s));
         wr(2'h0, 8'h01);
         // Processor keeps running for three cycles after the write, then stalls
         repeat (2) @(posedge hclk);
         @(negedge hclk) chk(cpu_stall, 1'b0);
         @(negedge hclk) chk(cpu_stall, 1'b1);
         @(posedge hclk);
         rd(2'h2, 8'h01, 8'h01);
         wr(2'h1, 8'($random(seed)));
         wr(2'h0, 8'h02);
         wr(2'h0, 8'h00);
         rd(2'h0, 8'h01);
         rd(2'h1, 8'(s));
         finish(s0, words(s));
         rd(2'h2, 8'h02);
         rd(2'h0, 8'h01);
      end
      // Strobe aborts a busy scan while fatal interrupt is disabled
      wr(2'h0, 8'h01);
      wr(2'h0, 8'h80);
      @(posedge hclk);
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h02);
      chk(cpu_stall, 1'b0);
      // Fatal enable survives strobe and zero writes
      wr(2'h0, 8'h02);
      rd(2'h0, 8'h02);
      wr(2'h0, 8'h80);
      @(posedge hclk);
      rd(2'h0, 8'h02);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h02);
      wr(2'h1, 8'h02);
      s0 = stall_cnt;
      wr(2'h0, 8'h03);
      wr(2'h0, 8'h80);
      rd(2'h2, 8'h01, 8'h01);
      rd(2'h0, 8'h03);
      finish(s0, 8);
      rd(2'h2, 8'h02);
      chk(fatal_irq, 1'b0);
      // Mismatch raises a sticky fatal request and freezes control
      corrupt <= 1'b1;
      s0 = stall_cnt;
      wr(2'h0, 8'h03);
      finish(s0, 8);
      rd(2'h2, 8'h00);
      chk(fatal_irq, 1'b1);
      wr(2'h0, 8'h80);
      wr(2'h1, 8'h01);
      @(posedge hclk);
      rd(2'h0, 8'h03);
      rd(2'h1, 8'h02);
      chk(fatal_irq, 1'b1);
      // Start-up scan from the straps after a system reset
      boot_en <= 1'b1;
      boot_sec <= 2'h1;
      corrupt <= 1'b0;
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      chk(fatal_irq, 1'b0);
      hresetn <= 1'b1;
      repeat (3 * 16 + 12) @(posedge hclk);
      rd(2'h0, 8'h01);
      rd(2'h1, 8'h01);
      rd(2'h2, 8'h02);
      repeat (2) @(posedge hclk);
      report_and_stop();
   end
endmodule
`default_nettype wire
